// ===== core/csr_pkg.sv
/*
  Shared constants and types for the charger status and operation registers.
  Assumes a register port driven by the serial control engine and an analog
  charger core that supplies raw sense levels from its own timing.
*/
package csr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] CSR_ADDR_CHG_STATE = 8'h07;
  localparam logic [7:0] CSR_ADDR_BATT_STATE = 8'h08;
  localparam logic [7:0] CSR_ADDR_OPER_CTRL = 8'h09;

  // ==========================================================
  // field positions
  localparam int CSR_THERM_BIT = 6;
  localparam int CSR_TREG_BIT = 7;
  localparam int CSR_OVERCUR_BIT = 5;
  localparam int CSR_BSPARE_LO_BIT = 3;
  localparam int CSR_BSPARE_HI_BIT = 6;
  localparam int CSR_OPER_SPARE_BIT = 2;

  // ==========================================================
  // charger state codes
  localparam logic [3:0] CSR_CHG_TIMER_FAULT = 4'h6;
  localparam logic [3:0] CSR_CHG_CODE_RST = 4'h8;

  // ==========================================================
  // battery state codes
  localparam logic [2:0] CSR_BATT_NO_INPUT = 3'h0;
  localparam logic [2:0] CSR_BATT_LOW = 3'h1;
  localparam logic [2:0] CSR_BATT_TIMER_FAULT = 3'h2;
  localparam logic [2:0] CSR_BATT_ABOVE_PRECHG = 3'h4;
  localparam logic [2:0] CSR_BATT_OVERVOLT = 3'h5;
  localparam logic [2:0] CSR_BATT_ABSENT = 3'h6;

  // ==========================================================
  // operation select
  typedef enum logic [1:0] {
    CSR_OP_ALL_OFF = 2'h0,
    CSR_OP_LINEAR = 2'h1,
    CSR_OP_CHARGE = 2'h2,
    CSR_OP_RSVD = 2'h3
  } csr_op_t;
  localparam logic [1:0] CSR_OPER_RST = 2'h1;

  // ==========================================================
  // raw sense levels from the analog core
  typedef struct packed {
    logic thermal_out_of_window;
    logic die_temp_over_reg;
    logic input_valid;
    logic batt_below_precharge;
    logic precharge_timer_fault;
    logic batt_overvoltage;
    logic batt_absent;
    logic system_awake;
    logic batt_overcurrent;
    logic [3:0] charger_core_code;
  } csr_sense_t;
  localparam int CSR_SENSE_W = 13;
  localparam logic [12:0] CSR_SENSE_RST = {9'h000, CSR_CHG_CODE_RST};

  // power path enables towards the analog core
  typedef struct packed {
    logic charger_on;
    logic linear_on;
    logic battery_path_switch_on;
  } csr_path_t;

endpackage : csr_pkg

// ===== core/csr_sense_sync.sv
/*
  Three-stage synchroniser for a vector of slow analog sense levels.
  Assumes inputs may change at any time; a bit is accepted only once the
  second and third stages agree, which filters single-sample glitches.
*/
module csr_sense_sync #(
  parameter int W = 13,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // raw and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;
  logic [W-1:0] stage3_ff;
  logic [W-1:0] clean_ff;
  logic [W-1:0] agree;
  logic [W-1:0] nxt_clean;

  // ==========================================================
  // filter
  assign agree = ~(stage2_ff ^ stage3_ff);
  assign nxt_clean = (agree & stage3_ff) | (~agree & clean_ff);
  assign clean = clean_ff;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      stage1_ff <= RST_VAL;
      stage2_ff <= RST_VAL;
      stage3_ff <= RST_VAL;
      clean_ff <= RST_VAL;
    end
    else
    begin
      stage1_ff <= raw;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
      clean_ff <= nxt_clean;
    end
  end

endmodule : csr_sense_sync

// ===== core/csr_regs.sv
/*
  Charger status and operation register bank.
  Assumes the serial control engine presents single-cycle read and write
  strobes with an 8-bit offset, and that rst is the core digital reset.
*/
module csr_regs (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port from serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // analog sense levels and fuses
  input wire csr_pkg::csr_sense_t sense_raw,
  input wire logic [1:0] fuse_op_select,
  // power path controls
  output csr_pkg::csr_path_t path_ctrl
);
  import csr_pkg::*;

  csr_sense_t sense;
  logic [CSR_SENSE_W-1:0] sense_vec;
  logic [7:0] chg_state_ff;
  logic [7:0] nxt_chg_state;
  logic [7:0] batt_state_ff;
  logic [7:0] nxt_batt_state;
  logic [3:0] batt_spare_ff;
  logic oper_spare_ff;
  logic [1:0] op_select_ff;
  logic [1:0] nxt_op_select;
  logic fuse_loaded_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  csr_path_t path_ff;
  csr_path_t nxt_path;
  logic [3:0] chg_code;
  logic [2:0] batt_code;
  logic wr_batt;
  logic wr_oper;
  logic op_write_ok;
  logic [7:0] rd_mux;
  logic [7:0] oper_view;
  logic [7:0] batt_view;

  // ==========================================================
  // sense synchroniser
  csr_sense_sync #(
    .W(CSR_SENSE_W),
    .RST_VAL(CSR_SENSE_RST)
  ) u_csr_sense_sync (
    .clock(clock),
    .rst(rst),
    .raw(sense_raw),
    .clean(sense_vec)
  );
  assign sense = csr_sense_t'(sense_vec);

  // ==========================================================
  // battery and charger state encoders
  // battery code priority
  assign batt_code = !sense.input_valid ? CSR_BATT_NO_INPUT :
                     (sense.batt_absent && sense.system_awake) ? CSR_BATT_ABSENT :
                     sense.batt_overvoltage ? CSR_BATT_OVERVOLT :
                     sense.precharge_timer_fault ? CSR_BATT_TIMER_FAULT :
                     sense.batt_below_precharge ? CSR_BATT_LOW :
                     CSR_BATT_ABOVE_PRECHG;

  assign chg_code = sense.precharge_timer_fault ? CSR_CHG_TIMER_FAULT :
                    sense.charger_core_code;

  assign nxt_chg_state = {sense.die_temp_over_reg, sense.thermal_out_of_window, 2'b00, chg_code};
  assign nxt_batt_state = {batt_spare_ff[3:2], sense.batt_overcurrent, batt_spare_ff[1:0], batt_code};

  // ==========================================================
  // write decode
  assign wr_batt = reg_wr && (reg_addr == CSR_ADDR_BATT_STATE);
  assign wr_oper = reg_wr && (reg_addr == CSR_ADDR_OPER_CTRL);
  // reserved select code is refused on host writes; a reserved fuse code still loads, and the default decode drives the battery path switch
  assign op_write_ok = wr_oper && (reg_wdata[1:0] != CSR_OP_RSVD);

  assign nxt_op_select = !fuse_loaded_ff ? fuse_op_select :
                         op_write_ok ? reg_wdata[1:0] :
                         op_select_ff;

  // ==========================================================
  // path decode
  always_comb
  begin
    nxt_path = '0;
    case (csr_op_t'(op_select_ff))
      CSR_OP_ALL_OFF:
      begin
        nxt_path.battery_path_switch_on = 1'b1;
      end
      CSR_OP_LINEAR:
      begin
        nxt_path.linear_on = 1'b1;
      end
      CSR_OP_CHARGE:
      begin
        nxt_path.charger_on = 1'b1;
        nxt_path.linear_on = 1'b1;
      end
      default:
      begin
        nxt_path.battery_path_switch_on = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // read mux
  assign oper_view = {5'b0_0000, oper_spare_ff, op_select_ff};
  // spares come straight from their flops, so a read right after a write sees the new value
  assign batt_view = {batt_spare_ff[3:2], batt_state_ff[CSR_OVERCUR_BIT], batt_spare_ff[1:0], batt_state_ff[2:0]};
  assign rd_mux = (reg_addr == CSR_ADDR_CHG_STATE) ? chg_state_ff :
                  (reg_addr == CSR_ADDR_BATT_STATE) ? batt_view :
                  (reg_addr == CSR_ADDR_OPER_CTRL) ? oper_view :
                  8'h00;

  // ==========================================================
  // status registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      chg_state_ff <= {4'h0, CSR_CHG_CODE_RST};
      batt_state_ff <= 8'h00;
    end
    else
    begin
      chg_state_ff <= nxt_chg_state;
      batt_state_ff <= nxt_batt_state;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      op_select_ff <= CSR_OPER_RST;
      fuse_loaded_ff <= 1'b0;
      batt_spare_ff <= 4'h0;
      oper_spare_ff <= 1'b0;
    end
    else
    begin
      op_select_ff <= nxt_op_select;
      fuse_loaded_ff <= 1'b1;
      if (wr_batt)
      begin
        batt_spare_ff <= {reg_wdata[CSR_BSPARE_HI_BIT+1:CSR_BSPARE_HI_BIT],
                          reg_wdata[CSR_BSPARE_LO_BIT+1:CSR_BSPARE_LO_BIT]};
      end
      if (wr_oper)
      begin
        oper_spare_ff <= reg_wdata[CSR_OPER_SPARE_BIT];
      end
    end
  end

  // ==========================================================
  // outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      path_ff <= '0;
    end
    else
    begin
      rdata_ff <= reg_rd ? rd_mux : rdata_ff;
      rvalid_ff <= reg_rd;
      path_ff <= nxt_path;
    end
  end

  assign reg_rdata = rdata_ff;
  assign reg_rvalid = rvalid_ff;
  assign path_ctrl = path_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_thermal_bit;
    $past(sense.thermal_out_of_window) == chg_state_ff[CSR_THERM_BIT];
  endproperty
  a_thermal_bit: assert property (p_thermal_bit) else $error("thermal bit wrong");

  property p_treg_bit;
    !$past(rst) |-> chg_state_ff[CSR_TREG_BIT] == $past(sense.die_temp_over_reg);
  endproperty
  a_treg_bit: assert property (p_treg_bit) else $error("regulation bit wrong");

  property p_reset_defaults;
    $past(rst) |-> chg_state_ff == 8'h08 && batt_state_ff == 8'h00;
  endproperty
  a_reset_defaults: assert property (@(posedge clock) p_reset_defaults) else $error("sense not reset");

  property p_no_input_code;
    !$past(sense.input_valid) && !$past(rst) |-> batt_state_ff[2:0] == 3'h0;
  endproperty
  a_no_input_code: assert property (p_no_input_code) else $error("code not zero without input");

  property p_timer_fault_pair;
    batt_state_ff[2:0] == 3'h2 |-> chg_state_ff[3:0] == 4'h6;
  endproperty
  a_timer_fault_pair: assert property (p_timer_fault_pair) else $error("timer fault not mirrored");

  property p_ov_needs_input;
    batt_state_ff[2:0] == 3'h5 |-> $past(sense.input_valid);
  endproperty
  a_ov_needs_input: assert property (p_ov_needs_input) else $error("overvoltage without input");

  property p_absent_code;
    $past(sense.input_valid && sense.batt_absent && sense.system_awake) && !$past(rst)
      |-> batt_state_ff[2:0] == 3'h6;
  endproperty
  a_absent_code: assert property (p_absent_code) else $error("absent battery not reported");

  property p_overcur_bit;
    !$past(rst) |-> batt_state_ff[CSR_OVERCUR_BIT] == $past(sense.batt_overcurrent);
  endproperty
  a_overcur_bit: assert property (p_overcur_bit) else $error("overcurrent bit wrong");

  property p_sel0_path;
    op_select_ff == 2'h0 |=> path_ctrl == 3'b001;
  endproperty
  a_sel0_path: assert property (p_sel0_path) else $error("select 0 path wrong");

  property p_sel1_path;
    op_select_ff == 2'h1 |=> path_ctrl == 3'b010;
  endproperty
  a_sel1_path: assert property (p_sel1_path) else $error("select 1 path wrong");

  property p_sel2_path;
    op_select_ff == 2'h2 |=> path_ctrl == 3'b110;
  endproperty
  a_sel2_path: assert property (p_sel2_path) else $error("select 2 path wrong");

  property p_sel_reset;
    $past(rst) |-> op_select_ff == 2'h1;
  endproperty
  a_sel_reset: assert property (@(posedge clock) p_sel_reset) else $error("select reset wrong");

  property p_fuse_load;
    $past(rst) ##1 !$past(rst) |-> op_select_ff == $past(fuse_op_select);
  endproperty
  a_fuse_load: assert property (@(posedge clock) disable iff (rst) p_fuse_load) else $error("fuse not loaded");

  property p_host_write;
    fuse_loaded_ff && reg_wr && reg_addr == CSR_ADDR_OPER_CTRL && reg_wdata[1:0] != CSR_OP_RSVD
      |=> op_select_ff == $past(reg_wdata[1:0]);
  endproperty
  a_host_write: assert property (p_host_write) else $error("host write lost");

  property p_ro_write;
    reg_wr && reg_addr == CSR_ADDR_CHG_STATE && $stable(sense)
      |=> chg_state_ff == $past(chg_state_ff) || $past(chg_state_ff) == $past(nxt_chg_state) ;
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only bits written");

  property p_read_latency;
    reg_rd |=> reg_rvalid && reg_rdata == $past(rd_mux);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer wrong");

  c_timer_fault: cover property (batt_state_ff[2:0] == 3'h2);
  c_charge_mode: cover property (path_ctrl.charger_on);
  c_host_select0: cover property (wr_oper ##1 op_select_ff == 2'h0);
  c_overvolt: cover property (batt_state_ff[2:0] == 3'h5);

endmodule : csr_regs

// ===== sim/csr_host.sv
/*
  Host model: drives the register strobe port the way the serial control
  engine would. Assumes a single clock and a registered read answer.
*/
module csr_host (
  // clock
  input wire logic clock,
  // requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  // answers
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5a;
    reg_wdata = 8'ha5;
  end

  // released lines show the inverse so a stale value is never mistaken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    n = 0;
    while (reg_rvalid !== 1'b1 && n < 4)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : csr_host

// ===== sim/csr_regs_test.sv
/*
  Self-checking bench for the charger register bank.
  Assumes the host model in csr_host and sense levels driven directly.
*/
module csr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import csr_pkg::*;

  // ==========================================================
  // signals and instances
  logic clock = 1'b0;
  logic rst = 1'b1;
  csr_sense_t sense_raw = {9'h000, 4'h8};
  logic [1:0] fuse_op_select = 2'h2;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  csr_path_t path_ctrl;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  csr_regs u_csr_regs (.clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sense_raw(sense_raw), .fuse_op_select(fuse_op_select), .path_ctrl(path_ctrl));

  csr_host u_csr_host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  // ==========================================================
  // checking helpers
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp3(input string what, input logic [2:0] exp, input logic [2:0] got);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s exp %b got %b", what, exp, got);
    end
  endtask : cmp3

  task automatic chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_csr_host.rd(a, d);
    cmp8(what, exp, d);
  endtask : chk

  // sense path needs about five edges; eight leaves margin
  task automatic settle(input csr_sense_t s);
    @(posedge clock);
    #1;
    sense_raw = s;
    repeat (8) @(posedge clock);
  endtask : settle

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  // ==========================================================
  // scenarios
  task automatic t_reset(input logic [1:0] fz, input logic [2:0] ep);
    @(posedge clock);
    #1;
    rst = 1'b1;
    fuse_op_select = fz;
    sense_raw = {9'h000, 4'h8};
    repeat (5) @(posedge clock);
    #1;
    cmp3("path in reset", 3'b000, path_ctrl);
    cmp8("rdata in reset", 8'h00, reg_rdata);
    rst = 1'b0;
    @(posedge clock);
    #1;
    cmp3("path default", 3'b010, path_ctrl);
    @(posedge clock);
    #1;
    cmp3("path fuse", ep, path_ctrl);
    chk("charger sense", 8'h07, 8'h08);
    chk("battery sense", 8'h08, 8'h00);
    chk("operation", 8'h09, {6'h00, fz});
    $display("test reset done");
  endtask : t_reset

  task automatic t_flags();
    settle({9'b110000001, 4'h8});
    chk("charger flags", 8'h07, 8'hc8);
    chk("overcurrent", 8'h08, 8'h20);
    settle({9'b100000000, 4'h8});
    chk("thermal only", 8'h07, 8'h48);
    chk("overcurrent off", 8'h08, 8'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_batt();
    logic [8:0] f [7] = '{9'b000001000, 9'b001100000, 9'b001110000, 9'b001000000,
      9'b001001000, 9'b001000110, 9'b001000100};
    logic [7:0] eb [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h06, 8'h04};
    logic [7:0] ec [7] = '{8'h03, 8'h03, 8'h06, 8'h03, 8'h03, 8'h03, 8'h03};
    for (int i = 0; i < 7; i++)
    begin
      settle({f[i], 4'h3});
      chk("battery code", 8'h08, eb[i]);
      chk("charger code", 8'h07, ec[i]);
    end
    $display("test battery done");
  endtask : t_batt

  task automatic t_ro();
    u_csr_host.wr(8'h07, 8'hff);
    u_csr_host.wr(8'h08, 8'hff);
    chk("charger after write", 8'h07, 8'h03);
    chk("battery after write", 8'h08, 8'hdc);
    chk("unmapped", 8'h0a, 8'h00);
    $display("test read-only done");
  endtask : t_ro

  task automatic t_oper();
    logic [2:0] ep [3] = '{3'b001, 3'b010, 3'b110};
    for (int i = 0; i < 3; i++)
    begin
      u_csr_host.wr(8'h09, 8'(i));
      chk("select", 8'h09, 8'(i));
      cmp3("path", ep[i], path_ctrl);
    end
    u_csr_host.wr(8'h09, 8'h07);
    chk("reserved select", 8'h09, 8'h06);
    cmp3("path kept", 3'b110, path_ctrl);
    $display("test operation done");
  endtask : t_oper

  // ==========================================================
  // sequence and cycle limit
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      $display("[ERR] cycle limit exp under 3000 got %0d", cycles);
      finish_test();
    end
  end

  initial
  begin
    t_reset(2'h2, 3'b110);
    t_flags();
    t_batt();
    t_ro();
    t_oper();
    t_reset(2'h0, 3'b001);
    finish_test();
  end
endmodule : csr_regs_test
